//--- design/scs_clock_select.sv
/*
 scs_clock_select: system clock source selection and external oscillator control.
 oscillator activity arrives as one-cycle tick pulses synchronous to i_clk; the
 system clock leaves as a one-cycle enable pulse o_sys_tick. registers sit on an
 8-bit special function register port with address, write strobe and read data.
*/
`include "scs_defines.svh"

// Behaviour
// - select bit 0: internal divided source; 1: external oscillator source.
// - select register upper seven bits read zero; software writes zeros.
// - internal source selectable immediately after enabling it, no start-up wait.
// - external oscillator output reaches timers and counter array regardless of selection.
// - crystal valid flag in bit 7 set once crystal runs stable, crystal modes.
// - mode 00x off, 010 cmos, 100 rc, 101 capacitor, 110 crystal.
// - modes 011 and 111 add divide-by-two to cmos and crystal.
// - control bit 3 reserved: reads zero, writes ignored.
// - crystal mode claims P0.2 and P0.3; rc, capacitor, cmos claim P0.3 only.
// - both registers reset to zero: external off, internal drives system clock.
// - internal divider field: 00 /8, 01 /4, 10 /2, 11 /1.
module scs_clock_select
   import scs_pkg::*;
#(
   parameter int SETTLE_CYC = `SCS_XTAL_SETTLE_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   input wire logic [1:0] i_internal_divider_field,
   input wire logic i_int_osc_tick,
   input wire logic i_ext_osc_tick,
   input wire logic i_amp_ok,
   output logic o_sys_tick,
   output logic o_ext_periph_tick,
   output logic [2:0] o_ext_osc_freq_control,
   output logic [2:0] o_ext_osc_drive_mode,
   output logic o_ext_osc_en,
   output logic o_osc_pin_in_claim,
   output logic o_osc_pin_out_claim,
   output logic o_sys_src_ext
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic clock_source_select_bit_r;
   scs_mode_t ext_osc_mode_field_r;
   logic [2:0] ext_osc_freq_control_r;
   logic crystal_valid_flag_r;
   logic [$clog2(SETTLE_CYC+1)-1:0] settle_cnt_r;
   logic wr_sel;
   logic wr_xosc;
   logic xtal_mode;

   assign wr_sel = i_sfr_wr && (i_sfr_addr == `SCS_ADDR_CLK_SEL);
   assign wr_xosc = i_sfr_wr && (i_sfr_addr == `SCS_ADDR_XOSC_CTL);
   assign xtal_mode = ext_osc_mode_field_r[2] && ext_osc_mode_field_r[1];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clock_source_select_bit_r <= 1'(`SCS_CLK_SEL_RESET >> `SCS_CLK_SEL_BIT);
      end else if (wr_sel) begin
         // upper bits are not stored, so they always read back zero
         clock_source_select_bit_r <= i_sfr_wdata[`SCS_CLK_SEL_BIT];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_osc_mode_field_r <= scs_mode_t'(3'(`SCS_XOSC_CTL_RESET >> `SCS_MODE_LSB));
         ext_osc_freq_control_r <= 3'(`SCS_XOSC_CTL_RESET >> `SCS_FREQ_LSB);
      end else if (wr_xosc) begin
         // bit 7 is read only and bit 3 is dropped
         ext_osc_mode_field_r <= scs_mode_t'(i_sfr_wdata[`SCS_MODE_MSB:`SCS_MODE_LSB]);
         ext_osc_freq_control_r <= i_sfr_wdata[`SCS_FREQ_MSB:`SCS_FREQ_LSB];
      end
   end

   // ----------------------------------------------------------------
   // crystal valid: amplitude detector must hold good for settle time
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         settle_cnt_r <= '0;
         crystal_valid_flag_r <= 1'b0;
      end else if (!xtal_mode || !i_amp_ok || wr_xosc) begin
         // any rewrite of the control register restarts the settle window
         settle_cnt_r <= '0;
         crystal_valid_flag_r <= 1'b0;
      end else if (settle_cnt_r < ($bits(settle_cnt_r))'(SETTLE_CYC)) begin
         settle_cnt_r <= settle_cnt_r + 1'b1;
      end else begin
         crystal_valid_flag_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // readback
   // ----------------------------------------------------------------
   always_comb begin
      o_sfr_rdata = 8'h00;
      if (i_sfr_addr == `SCS_ADDR_CLK_SEL) begin
         o_sfr_rdata = {7'h00, clock_source_select_bit_r};
      end else if (i_sfr_addr == `SCS_ADDR_XOSC_CTL) begin
         o_sfr_rdata = {crystal_valid_flag_r, ext_osc_mode_field_r, 1'b0,
                        ext_osc_freq_control_r};
      end
   end

   // ----------------------------------------------------------------
   // external oscillator mode decode
   // ----------------------------------------------------------------
   logic ext_on;
   logic ext_div2;
   always_comb begin
      ext_on = 1'b1;
      ext_div2 = 1'b0;
      unique case (ext_osc_mode_field_r)
         SCS_MODE_OFF0, SCS_MODE_OFF1: ext_on = 1'b0;
         SCS_MODE_CMOS, SCS_MODE_RC, SCS_MODE_CAP, SCS_MODE_XTAL: ext_div2 = 1'b0;
         SCS_MODE_CMOS_DIV2, SCS_MODE_XTAL_DIV2: ext_div2 = 1'b1;
      endcase
   end

   assign o_ext_osc_en = ext_on;
   assign o_ext_osc_drive_mode = ext_osc_mode_field_r;
   assign o_ext_osc_freq_control = ext_osc_freq_control_r;
   assign o_osc_pin_in_claim = ext_on && xtal_mode;
   assign o_osc_pin_out_claim = ext_on;

   logic ext_src_tick;
   logic int_src_tick;

   scs_clk_div #(.CNT_W(3)) u_ext_div (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tick(i_ext_osc_tick && ext_on),
      .i_ratio_m1({2'b00, ext_div2}),
      .o_tick(ext_src_tick)
   );

   // divider field 00 gives /8 down to 11 giving /1
   function automatic logic [2:0] idiv_ratio_m1(input logic [1:0] f);
      idiv_ratio_m1 = 3'((4'h8 >> f) - 4'h1);
   endfunction

   scs_clk_div #(.CNT_W(3)) u_int_div (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tick(i_int_osc_tick),
      .i_ratio_m1(idiv_ratio_m1(i_internal_divider_field)),
      .o_tick(int_src_tick)
   );

   assign o_ext_periph_tick = ext_src_tick;

   // ----------------------------------------------------------------
   // glitch-free switch: old source finishes its period, then new one
   // ----------------------------------------------------------------
   scs_sw_t sw_r;
   logic cur_ext_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sw_r <= SCS_SW_RUN;
         cur_ext_r <= 1'b0;
      end else begin
         unique case (sw_r)
            SCS_SW_RUN: if (clock_source_select_bit_r != cur_ext_r) begin
               sw_r <= SCS_SW_STOP_OLD;
            end
            // wait for the old source's last tick so its period is not cut
            SCS_SW_STOP_OLD: if (cur_ext_r ? ext_src_tick : int_src_tick) begin
               sw_r <= SCS_SW_WAIT_NEW;
               cur_ext_r <= clock_source_select_bit_r;
            end
            // internal starts without delay; no settle gate needed here
            SCS_SW_WAIT_NEW: sw_r <= SCS_SW_RUN;
            default: sw_r <= SCS_SW_RUN;
         endcase
      end
   end

   assign o_sys_tick = (sw_r == SCS_SW_WAIT_NEW) ? 1'b0 :
                       (cur_ext_r ? ext_src_tick : int_src_tick);
   assign o_sys_src_ext = cur_ext_r;

endmodule

//--- design/scs_defines.svh
/*
 clock source select constants: register addresses, field positions, reset values,
 and timing counts. assumes an 8-bit special function register port.
*/
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_ADDR_CLK_SEL 8'ha9
`define SCS_ADDR_XOSC_CTL 8'hb1
`define SCS_CLK_SEL_RESET 8'h00
`define SCS_XOSC_CTL_RESET 8'h00
`define SCS_CLK_SEL_BIT 0
`define SCS_XVALID_BIT 7
`define SCS_MODE_MSB 6
`define SCS_MODE_LSB 4
`define SCS_RSVD_BIT 3
`define SCS_FREQ_MSB 2
`define SCS_FREQ_LSB 0
`define SCS_IDIV_RESET 2'h0
// crystal settle time before the valid flag may be trusted, in us
`define SCS_XTAL_SETTLE_US 1000
`define SCS_CLK_MHZ 10
`define SCS_XTAL_SETTLE_CYC (`SCS_XTAL_SETTLE_US * `SCS_CLK_MHZ)

`endif

//--- design/scs_pkg.sv
/*
 types for the clock source select block.
 assumes scs_defines.svh is included by the design files that need the constants.
*/
package scs_pkg;

   typedef enum logic [2:0] {
      SCS_MODE_OFF0 = 3'h0,
      SCS_MODE_OFF1 = 3'h1,
      SCS_MODE_CMOS = 3'h2,
      SCS_MODE_CMOS_DIV2 = 3'h3,
      SCS_MODE_RC = 3'h4,
      SCS_MODE_CAP = 3'h5,
      SCS_MODE_XTAL = 3'h6,
      SCS_MODE_XTAL_DIV2 = 3'h7
   } scs_mode_t;

   // switch states, gray from SCS_SW_RUN to SCS_SW_STOP_OLD to SCS_SW_WAIT_NEW; the return to SCS_SW_RUN flips both bits
   typedef enum logic [1:0] {
      SCS_SW_RUN = 2'b00,
      SCS_SW_STOP_OLD = 2'b01,
      SCS_SW_WAIT_NEW = 2'b11
   } scs_sw_t;

endpackage

//--- design/scs_clk_div.sv
/*
 scs_clk_div: turns a source tick stream into a divided enable stream.
 assumes i_tick pulses one cycle per source clock edge, synchronous to i_clk.
*/
module scs_clk_div
   import scs_pkg::*;
#(
   parameter int CNT_W = 3
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_tick,
   input wire logic [CNT_W-1:0] i_ratio_m1,
   output logic o_tick
);

   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
      end else if (i_tick) begin
         if (cnt_r >= i_ratio_m1) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end

   assign o_tick = i_tick && (cnt_r >= i_ratio_m1);

endmodule

//--- bench/scs_osc_model.sv
/* oscillator side: internal and external tick sources, amplitude detector.
   assumes the bench clock; changes on the falling edge. */
module scs_osc_model (
   input wire logic i_clk,
   input wire logic i_en,
   input wire logic i_xtal,
   output logic o_int_tick,
   output logic o_ext_tick,
   output logic o_amp_ok
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph = 2'h0;
   logic it = 1'b0;
   always @(negedge i_clk) begin
      it <= ~it;
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
   end
   assign o_int_tick = it;
   // an external source that is off stands still
   assign o_ext_tick = i_en && ph == 2'h0;
   // crystal only starts once both pins are handed to it
   assign o_amp_ok = i_xtal;
endmodule

//--- bench/scs_clock_select_chk.sv
/* checker: readback, mode decode, pin claims, tick routing.
   assumes binding onto scs_clock_select. */
`include "scs_defines.svh"
module scs_clock_select_chk (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic i_ext_osc_tick,
   input wire logic o_sys_tick,
   input wire logic o_ext_periph_tick,
   input wire logic [2:0] o_ext_osc_freq_control,
   input wire logic [2:0] o_ext_osc_drive_mode,
   input wire logic o_ext_osc_en,
   input wire logic o_osc_pin_in_claim,
   input wire logic o_osc_pin_out_claim,
   input wire logic o_sys_src_ext
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire logic xc = i_sfr_addr == `SCS_ADDR_XOSC_CTL;
   wire logic xt = o_ext_osc_drive_mode[2:1] == 2'h3;
   property p_sel; i_sfr_addr == `SCS_ADDR_CLK_SEL |-> o_sfr_rdata[7:1] == 7'h00; endproperty
   a_sel: assert property (p_sel) else $error("select high bits set");
   property p_rsvd; xc |-> !o_sfr_rdata[3]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_wr; i_sfr_wr && xc |=> {1'b0, o_ext_osc_drive_mode, 1'b0,
      o_ext_osc_freq_control} == ($past(i_sfr_wdata) & 8'h77); endproperty
   a_wr: assert property (p_wr) else $error("control fields");
   property p_en; o_ext_osc_en == (o_ext_osc_drive_mode[2:1] != 2'h0); endproperty
   a_en: assert property (p_en) else $error("enable decode");
   property p_pin; o_osc_pin_in_claim == xt && o_osc_pin_out_claim == o_ext_osc_en; endproperty
   a_pin: assert property (p_pin) else $error("pin claims");
   property p_vld; xc && o_sfr_rdata[7] |-> xt; endproperty
   a_vld: assert property (p_vld) else $error("valid outside crystal");
   property p_vwr; i_sfr_wr && xc |=> !(xc && o_sfr_rdata[7]); endproperty
   a_vwr: assert property (p_vwr) else $error("valid after rewrite");
   property p_ext; o_sys_tick && o_sys_src_ext && $past(o_sys_src_ext) |-> o_ext_periph_tick;
   endproperty
   a_ext: assert property (p_ext) else $error("external tick source");
   property p_per; o_ext_periph_tick |-> i_ext_osc_tick; endproperty
   a_per: assert property (p_per) else $error("peripheral tick");
   property p_sw; $changed(o_sys_src_ext) |-> !o_sys_tick; endproperty
   a_sw: assert property (p_sw) else $error("tick during source change");
endmodule
bind scs_clock_select scs_clock_select_chk u_scs_clock_select_chk (.*);

//--- bench/tb_scs_clock_select.sv
/* bench for scs_clock_select: registers, modes, divider, valid flag, switching.
   assumes scs_osc_model as the oscillator side. */
`include "scs_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_scs_clock_select;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_rst_n = 0, i_sfr_wr = 0, amp, it, et, st, pt, en, pi, po, sx;
   logic [7:0] i_sfr_addr = `SCS_ADDR_CLK_SEL, i_sfr_wdata = 0, rdata;
   logic [1:0] dv = 0;
   logic [2:0] fq, md;
   int num_errors = 0, samples_checked = 0, ns, np;
   // written byte, readback, {pin in, pin out, enable}
   logic [18:0] rows [8] = '{{8'h8f, 8'h07, 3'h0}, {8'h1a, 8'h12, 3'h0}, {8'h2b, 8'h23, 3'h3},
      {8'h3c, 8'h34, 3'h3}, {8'h45, 8'h45, 3'h3}, {8'h5e, 8'h56, 3'h3}, {8'h6d, 8'h65, 3'h7},
      {8'h7f, 8'h77, 3'h7}};
   scs_clock_select #(.SETTLE_CYC(8)) u_scs_clock_select (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
      .o_sfr_rdata(rdata), .i_internal_divider_field(dv), .i_int_osc_tick(it),
      .i_ext_osc_tick(et), .i_amp_ok(amp), .o_sys_tick(st), .o_ext_periph_tick(pt),
      .o_ext_osc_freq_control(fq), .o_ext_osc_drive_mode(md), .o_ext_osc_en(en),
      .o_osc_pin_in_claim(pi), .o_osc_pin_out_claim(po), .o_sys_src_ext(sx));
   scs_osc_model u_scs_osc_model (.i_clk(i_clk), .i_en(en), .i_xtal(pi), .o_int_tick(it),
      .o_ext_tick(et), .o_amp_ok(amp));
   always #50 i_clk = ~i_clk;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_sfr_addr = a;
      i_sfr_wdata = d;
      i_sfr_wr = 1;
      @(negedge i_clk);
      i_sfr_wr = 0;
   endtask
   task automatic cnt(input int n);
      ns = 0;
      np = 0;
      repeat (n) begin
         @(negedge i_clk);
         #1;
         ns += st;
         np += pt;
      end
   endtask
   task automatic wsrc(input logic v);
      for (int i = 0; i < 40 && sx !== v; i++) @(negedge i_clk);
   endtask
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (3) @(negedge i_clk);
      i_rst_n = 1;
      `CHK({rdata, sx, en}, 10'h000)
      i_sfr_addr = `SCS_ADDR_XOSC_CTL;
      #1 `CHK(rdata, 8'h00)
      i_sfr_addr = 8'h55;
      #1 `CHK(rdata, 8'h00)
      foreach (rows[i]) begin
         wr(`SCS_ADDR_XOSC_CTL, rows[i][18:11]);
         `CHK(rdata, rows[i][10:3])
         `CHK({md, fq}, {rows[i][9:7], rows[i][5:3]})
         `CHK({pi, po, en}, rows[i][2:0])
      end
      wr(`SCS_ADDR_XOSC_CTL, 8'h00);
      for (int d = 0; d < 4; d++) begin
         dv = 2'(d);
         cnt(20);
         cnt(96);
         `CHK(ns, 6 << d)
      end
      wr(`SCS_ADDR_CLK_SEL, 8'hfe);
      `CHK(rdata, 8'h00)
      // model crystal runs near 3.3 MHz, so frequency code 101
      wr(`SCS_ADDR_XOSC_CTL, 8'h65);
      repeat (4) @(negedge i_clk);
      `CHK(rdata[7], 1'b0)
      repeat (12) @(negedge i_clk);
      `CHK(rdata, 8'he5)
      wr(`SCS_ADDR_CLK_SEL, 8'h01);
      `CHK(rdata, 8'h01)
      wsrc(1);
      cnt(60);
      `CHK({sx, 8'(ns), 8'(np)}, {1'b1, 8'd20, 8'd20})
      wr(`SCS_ADDR_XOSC_CTL, 8'h75);
      cnt(6);
      cnt(60);
      `CHK({8'(ns), 8'(np)}, {8'd10, 8'd10})
      wr(`SCS_ADDR_CLK_SEL, 8'h00);
      wsrc(0);
      cnt(60);
      `CHK({sx, 8'(ns), 8'(np)}, {1'b0, 8'd30, 8'd10})
      i_rst_n = 0;
      #1 `CHK({rdata, pi, po, en}, 11'h000)
      complete_run();
   end
endmodule
